// [src/mtsb_pkg.sv]
// package: register map and field layout of the motor telemetry status bank
// Function
// - peak current code in bits 10:0
// - current amps from code, 1023 offset, /512
// - reserved upper bits read zero
// - rotor angle plus advance in bits 15:8
// - supply code in bits 7:0, 30V/255
// - active rate command in bits 15:8
// - buffered rate command in bits 7:0
// - analog input code bits 9:0, rail/1024
// - all telemetry registers reset to zero
// - bypass bit selects serial written command
`default_nettype none
package mtsb_pkg;
    localparam int unsigned MTSB_ADDR_W = 8;
    localparam int unsigned MTSB_DATA_W = 16;
    localparam int unsigned MTSB_CUR_W = 11;
    localparam int unsigned MTSB_BYTE_W = 8;
    localparam int unsigned MTSB_ANA_W = 10;
    localparam int unsigned MTSB_SER_W = 9;
    localparam logic [MTSB_ADDR_W-1:0] MTSB_OFS_CURRENT = 8'h04;
    localparam logic [MTSB_ADDR_W-1:0] MTSB_OFS_ANGLE_SUPPLY = 8'h05;
    localparam logic [MTSB_ADDR_W-1:0] MTSB_OFS_RATE_CMD = 8'h06;
    localparam logic [MTSB_ADDR_W-1:0] MTSB_OFS_ANALOG = 8'h07;
    localparam logic [MTSB_DATA_W-1:0] MTSB_RESET_VALUE = 16'h0000;
    localparam logic [MTSB_DATA_W-1:0] MTSB_UNMAPPED_VALUE = 16'h0000;
    localparam int unsigned MTSB_HI_LSB = 8;
    localparam int unsigned MTSB_SER_DROP = MTSB_SER_W - MTSB_BYTE_W;
    localparam int unsigned MTSB_RD_LATENCY = 1;

    typedef struct packed {
        logic [MTSB_CUR_W-1:0] peak_current_code;
        logic [MTSB_BYTE_W-1:0] initial_rotor_angle;
        logic [MTSB_BYTE_W-1:0] supply_level_code;
        logic [MTSB_BYTE_W-1:0] active_rate_command;
        logic [MTSB_BYTE_W-1:0] buffered_rate_command;
        logic [MTSB_ANA_W-1:0] analog_rate_input_code;
    } mtsb_telemetry_t;

    typedef struct packed {
        logic [MTSB_BYTE_W-1:0] analog_rate_command;
        logic [MTSB_BYTE_W-1:0] pulse_width_rate_input;
        logic [MTSB_SER_W-1:0] serial_rate_command;
        logic rate_write_bypass;
        logic pulse_width_mode;
    } mtsb_rate_src_t;
endpackage : mtsb_pkg
`default_nettype wire

// [src/mtsb_status_bank.sv]
// module: read-only telemetry register group behind the serial register port
`default_nettype none
module mtsb_status_bank
    import mtsb_pkg::*;
#(
    parameter int unsigned CUR_W = MTSB_CUR_W,
    parameter int unsigned ANA_W = MTSB_ANA_W
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [MTSB_CUR_W-1:0] peak_current_code_i,
    input wire logic [MTSB_BYTE_W-1:0] rotor_angle_raw_i,
    input wire logic [MTSB_BYTE_W-1:0] detection_advance_i,
    input wire logic [MTSB_BYTE_W-1:0] supply_level_code_i,
    input wire mtsb_rate_src_t rate_src_i,
    input wire logic [MTSB_BYTE_W-1:0] buffered_rate_command_i,
    input wire logic [MTSB_ANA_W-1:0] analog_rate_input_code_i,
    input wire logic [MTSB_ADDR_W-1:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [MTSB_DATA_W-1:0] reg_wdata_i,
    output logic [MTSB_DATA_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic reg_hit_o,
    output logic [MTSB_BYTE_W-1:0] active_rate_command_o
);

    // elaboration check: field widths are fixed by the layout
    if (CUR_W != MTSB_CUR_W || ANA_W != MTSB_ANA_W) begin : g_width_check
        $error("mtsb_status_bank: field widths are fixed by the register layout");
    end

    mtsb_telemetry_t tel;
    mtsb_telemetry_t next_tel;
    logic [MTSB_DATA_W-1:0] rdata;
    logic [MTSB_DATA_W-1:0] next_rdata;
    logic rvalid;
    logic next_rvalid;
    logic [MTSB_BYTE_W-1:0] src_cmd;

    function automatic logic addr_mapped(input logic [MTSB_ADDR_W-1:0] a);
        return (a == MTSB_OFS_CURRENT) || (a == MTSB_OFS_ANGLE_SUPPLY) ||
               (a == MTSB_OFS_RATE_CMD) || (a == MTSB_OFS_ANALOG);
    endfunction

    function automatic logic [MTSB_DATA_W-1:0] reg_view(
        input mtsb_telemetry_t t,
        input logic [MTSB_ADDR_W-1:0] a
    );
        logic [MTSB_DATA_W-1:0] v;
        v = MTSB_UNMAPPED_VALUE;
        unique case (a)
            MTSB_OFS_CURRENT: v = {{(MTSB_DATA_W-MTSB_CUR_W){1'b0}},
                                   t.peak_current_code};
            MTSB_OFS_ANGLE_SUPPLY: v = {t.initial_rotor_angle,
                                        t.supply_level_code};
            MTSB_OFS_RATE_CMD: v = {t.active_rate_command,
                                    t.buffered_rate_command};
            MTSB_OFS_ANALOG: v = {{(MTSB_DATA_W-MTSB_ANA_W){1'b0}},
                                  t.analog_rate_input_code};
            default: v = MTSB_UNMAPPED_VALUE;
        endcase
        return v;
    endfunction

    // command source: serial when bypass set, else pwm or analog
    always_comb begin
        if (rate_src_i.rate_write_bypass) begin
            src_cmd = rate_src_i.serial_rate_command[MTSB_SER_W-1:MTSB_SER_DROP];
        end else if (rate_src_i.pulse_width_mode) begin
            src_cmd = rate_src_i.pulse_width_rate_input;
        end else begin
            src_cmd = rate_src_i.analog_rate_command;
        end
    end

    // capture telemetry; host writes never reach it
    always_comb begin
        next_tel.peak_current_code = peak_current_code_i;
        next_tel.initial_rotor_angle = MTSB_BYTE_W'(rotor_angle_raw_i
                                                    + detection_advance_i);
        next_tel.supply_level_code = supply_level_code_i;
        next_tel.active_rate_command = src_cmd;
        next_tel.buffered_rate_command = buffered_rate_command_i;
        next_tel.analog_rate_input_code = analog_rate_input_code_i;
    end

    // read port: one cycle latency, writes dropped
    always_comb begin
        next_rvalid = reg_rd_i && !reg_wr_i;
        next_rdata = rdata;
        if (reg_rd_i && !reg_wr_i) begin
            next_rdata = reg_view(tel, reg_addr_i);
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            tel <= '0;
            rdata <= MTSB_RESET_VALUE;
            rvalid <= 1'b0;
        end else begin
            tel <= next_tel;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    assign reg_rdata_o = rdata;
    assign reg_rvalid_o = rvalid;
    assign reg_hit_o = addr_mapped(reg_addr_i) && (reg_rd_i || reg_wr_i);
    assign active_rate_command_o = tel.active_rate_command;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    AST_CUR_LAYOUT: assert property (reg_rd_i && !reg_wr_i && reg_addr_i == MTSB_OFS_CURRENT
        |=> reg_rvalid_o && reg_rdata_o[CUR_W-1:0] == $past(tel.peak_current_code))
        else $error("current field wrong");
    AST_RSV_ZERO: assert property (reg_rvalid_o && $past(reg_addr_i) == MTSB_OFS_CURRENT
        |-> reg_rdata_o[MTSB_DATA_W-1:CUR_W] == '0)
        else $error("current reserved bits not zero");
    AST_RSV_ANA_ZERO: assert property (reg_rvalid_o && $past(reg_addr_i) == MTSB_OFS_ANALOG
        |-> reg_rdata_o[MTSB_DATA_W-1:ANA_W] == '0)
        else $error("analog reserved bits not zero");
    AST_ANGLE_SUM: assert property (##1 tel.initial_rotor_angle ==
        MTSB_BYTE_W'($past(rotor_angle_raw_i) + $past(detection_advance_i)))
        else $error("rotor angle not raw plus advance");
    AST_ANGLE_SUPPLY_READ: assert property (reg_rd_i && !reg_wr_i
        && reg_addr_i == MTSB_OFS_ANGLE_SUPPLY |=> reg_rdata_o ==
        {$past(tel.initial_rotor_angle), $past(tel.supply_level_code)})
        else $error("angle supply word wrong");
    AST_SRC_SELECT: assert property (rate_src_i.rate_write_bypass |=>
        tel.active_rate_command ==
        $past(rate_src_i.serial_rate_command[MTSB_SER_W-1:MTSB_SER_DROP]))
        else $error("bypass did not select serial command");
    AST_SRC_ANALOG: assert property (!rate_src_i.rate_write_bypass
        && !rate_src_i.pulse_width_mode |=>
        tel.active_rate_command == $past(rate_src_i.analog_rate_command))
        else $error("analog command not selected");
    AST_RATE_READ: assert property (reg_rd_i && !reg_wr_i && reg_addr_i == MTSB_OFS_RATE_CMD
        |=> reg_rdata_o == {$past(tel.active_rate_command),
        $past(tel.buffered_rate_command)})
        else $error("rate command word wrong");
    AST_ANA_READ: assert property (reg_rd_i && !reg_wr_i && reg_addr_i == MTSB_OFS_ANALOG
        |=> reg_rdata_o[ANA_W-1:0] == $past(tel.analog_rate_input_code))
        else $error("analog code wrong");
    AST_WRITE_IGNORED: assert property (reg_wr_i |=> !reg_rvalid_o
        && reg_rdata_o == $past(reg_rdata_o))
        else $error("write disturbed read data");
    AST_RESET_ZERO: assert property (@(posedge clk_sys_i) disable iff (1'b0)
        $fell(reset_i) |-> reg_rdata_o == MTSB_RESET_VALUE && tel == '0)
        else $error("registers not zero after reset");
    AST_UNMAPPED: assert property (reg_rd_i && !reg_wr_i && !addr_mapped(reg_addr_i)
        |=> reg_rvalid_o && reg_rdata_o == MTSB_UNMAPPED_VALUE)
        else $error("unmapped read not zero");
    AST_NO_READ_NO_VALID: assert property (!(reg_rd_i && !reg_wr_i) |=> !reg_rvalid_o)
        else $error("read valid without accepted read");
    AST_RDATA_HOLD: assert property (!(reg_rd_i && !reg_wr_i) |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");
    AST_RD_WR_REFUSED: assert property (reg_rd_i && reg_wr_i |=> !reg_rvalid_o)
        else $error("read with write strobe was answered");
    AST_HIT_IDLE: assert property (!reg_rd_i && !reg_wr_i |-> !reg_hit_o)
        else $error("hit without a strobe");
    AST_SRC_PWM: assert property (!rate_src_i.rate_write_bypass
        && rate_src_i.pulse_width_mode |=>
        tel.active_rate_command == $past(rate_src_i.pulse_width_rate_input))
        else $error("pwm command not selected");
    AST_BUF_CAPTURE: assert property (##1 tel.buffered_rate_command ==
        $past(buffered_rate_command_i))
        else $error("buffered command not captured");

    COV_READ_CURRENT: cover property (reg_rd_i && reg_addr_i == MTSB_OFS_CURRENT);
    COV_BYPASS: cover property (rate_src_i.rate_write_bypass ##1 reg_rd_i
        && reg_addr_i == MTSB_OFS_RATE_CMD);
    COV_WRITE: cover property (reg_wr_i && addr_mapped(reg_addr_i));
    COV_PWM: cover property (rate_src_i.pulse_width_mode && !rate_src_i.rate_write_bypass);
    COV_UNMAPPED: cover property (reg_rd_i && !addr_mapped(reg_addr_i));

endmodule : mtsb_status_bank
`default_nettype wire

// [sim/mtsb_host_model.sv]
// host model: reads and writes over the bank's register port
`default_nettype none
module mtsb_host_model
    import mtsb_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic [MTSB_DATA_W-1:0] reg_rdata_i,
    input wire logic reg_rvalid_i,
    output logic [MTSB_ADDR_W-1:0] reg_addr_o = 8'h00,
    output logic reg_rd_o = 1'b0,
    output logic reg_wr_o = 1'b0,
    output logic [MTSB_DATA_W-1:0] reg_wdata_o = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ps;
    // reserved bits passed on whole, caller masks nothing
    task automatic rd(input logic [MTSB_ADDR_W-1:0] a, output logic [MTSB_DATA_W-1:0] d,
                      output bit ok);
        @(negedge clk_sys_i);
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(negedge clk_sys_i);
        reg_rd_o = 1'b0;
        ok = 1'b0;
        for (int n = 0; n < 4 && !ok; n++) begin
            if (reg_rvalid_i === 1'b1) begin
                ok = 1'b1;
                d = reg_rdata_i;
            end else @(negedge clk_sys_i);
        end
        reg_addr_o = ~a;
    endtask
    task automatic wr(input logic [MTSB_ADDR_W-1:0] a, input logic [MTSB_DATA_W-1:0] d);
        @(negedge clk_sys_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(negedge clk_sys_i);
        reg_wr_o = 1'b0;
        reg_wdata_o = ~d;
    endtask
endmodule // mtsb_host_model
`default_nettype wire

// [sim/tb_top.sv]
// testbench: telemetry reads, command source select, ignored writes
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mtsb_pkg::*;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic [MTSB_CUR_W-1:0] cur = '0;
    logic [MTSB_BYTE_W-1:0] ang = '0, adv = '0, sup = '0, bcmd = '0, act, ex;
    mtsb_rate_src_t src = '0;
    logic [MTSB_ANA_W-1:0] ana = '0;
    logic [MTSB_ADDR_W-1:0] addr;
    logic rd, wr, rvalid, hit;
    logic [MTSB_DATA_W-1:0] wdata, rdata, d;
    logic [MTSB_CUR_W-1:0] codes [4] = '{11'h000, 11'h3ff, 11'h400, 11'h7ff};
    bit ok;
    int err_count = 0;
    int cmp_count = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    mtsb_status_bank u_mtsb_status_bank (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .peak_current_code_i(cur), .rotor_angle_raw_i(ang), .detection_advance_i(adv),
        .supply_level_code_i(sup), .rate_src_i(src), .buffered_rate_command_i(bcmd),
        .analog_rate_input_code_i(ana), .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .reg_hit_o(hit),
        .active_rate_command_o(act));
    mtsb_host_model u_mtsb_host_model (.clk_sys_i(clk_sys_i), .reg_rdata_i(rdata),
        .reg_rvalid_i(rvalid), .reg_addr_o(addr), .reg_rd_o(rd), .reg_wr_o(wr),
        .reg_wdata_o(wdata));
    task automatic print_verdict();
        if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [MTSB_DATA_W-1:0] seen, input logic [MTSB_DATA_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic get(input logic [MTSB_ADDR_W-1:0] a, input logic [MTSB_DATA_W-1:0] exp);
        u_mtsb_host_model.rd(a, d, ok);
        if (!ok) begin
            err_count++;
            print_verdict();
        end else check(d, exp);
    endtask
    always @(posedge clk_sys_i) begin
        if (!reset_i && (rd || wr)) begin
            check({15'h0000, hit},
                  {15'h0000, addr >= MTSB_OFS_CURRENT && addr <= MTSB_OFS_ANALOG});
        end
    end
    initial begin
        cur = 11'h5a5;
        src.analog_rate_command = 8'h3c;
        repeat (6) @(negedge clk_sys_i);
        check(rdata, MTSB_RESET_VALUE);
        check({8'h00, act}, 16'h0000);
        check({15'h0000, rvalid}, 16'h0000);
        cur = '0;
        src = '0;
        reset_i = 1'b0;
        for (int i = 0; i < 4; i++) get(MTSB_OFS_CURRENT + 8'(i), 16'h0000);
        foreach (codes[i]) begin
            cur = codes[i];
            get(MTSB_OFS_CURRENT, {5'h00, codes[i]});
        end
        ang = 8'hf0;
        adv = 8'h25;
        sup = 8'h67;
        get(MTSB_OFS_ANGLE_SUPPLY, 16'h1567);
        ana = 10'h3ff;
        bcmd = 8'hff;
        get(MTSB_OFS_ANALOG, 16'h03ff);
        src = '{8'h5a, 8'hc3, 9'h1ab, 1'b0, 1'b0};
        for (int m = 0; m < 3; m++) begin
            src.rate_write_bypass = (m == 2);
            src.pulse_width_mode = (m == 1);
            ex = (m == 2) ? 8'hd5 : (m == 1) ? 8'hc3 : 8'h5a;
            get(MTSB_OFS_RATE_CMD, {ex, 8'hff});
            check({8'h00, act}, {8'h00, ex});
        end
        u_mtsb_host_model.wr(MTSB_OFS_ANGLE_SUPPLY, 16'hffff);
        get(MTSB_OFS_ANGLE_SUPPLY, 16'h1567);
        u_mtsb_host_model.wr(MTSB_OFS_RATE_CMD, 16'h0000);
        get(MTSB_OFS_RATE_CMD, 16'hd5ff);
        check({8'h00, act}, 16'h00d5);
        get(8'h08, MTSB_UNMAPPED_VALUE);
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
